// file: logic/mie_params.svh
`ifndef MIE_PARAMS_SVH
`define MIE_PARAMS_SVH
// ==========================================================
// register byte offsets
`define MIE_OFS_EN      8'h00
`define MIE_OFS_STS     8'h04
`define MIE_OFS_ACC     8'h08
`define MIE_OFS_PM      8'h0C
// ==========================================================
// enable and status bit positions
`define MIE_B_ACT_A     6
`define MIE_B_ACT_B     7
`define MIE_B_ACT_C     8
`define MIE_B_SUM1      9
`define MIE_B_REA_A     10
`define MIE_B_REA_B     11
`define MIE_B_REA_C     12
`define MIE_B_SUM2      13
`define MIE_B_PLS1      14
`define MIE_B_PLS2      15
`define MIE_B_PLS3      16
`define MIE_B_DSP       17
`define MIE_B_SUM3      18
// writable enable bits and reset values
`define MIE_EN_MASK     32'h0007_FFC0
`define MIE_EN_RST      32'h0000_0000
`define MIE_ACC_RST     8'h00
`define MIE_PM_RST      16'h0000
// ==========================================================
// mode register fields
`define MIE_ACC_ASEL    6
`define MIE_ACC_RSEL    7
`define MIE_PM_SEL1_LO  0
`define MIE_PM_SEL2_LO  3
`define MIE_PM_SEL3_LO  6
`define MIE_PM_DIS1     9
`define MIE_PM_DIS2     10
`define MIE_PM_DIS3     11
`define MIE_HTRANS_NSEQ 2'h2
`endif

// file: logic/mie_pkg.sv
`default_nettype none
// ==========================================================
// shared types
package mie_pkg;
  typedef logic [31:0] mie_word_t;
  typedef logic [2:0]  mie_psel_t;
  typedef logic [2:0]  mie_phase_t;
endpackage
`default_nettype wire

// file: logic/mie_irq_top.sv
// Function
// - enable bit 6 lets a sign change of the selected phase A active power raise the interrupt.
// - enable bit 7 lets a sign change of the selected phase B active power raise the interrupt.
// - bit 8 is the phase C counterpart for active power sign changes.
// - accumulation mode bit 6 picks total or fundamental active power for those events.
// - bits 10 to 12 cover reactive power sign changes of phases A to C, picked by mode bit 7.
// - enable bit 9 covers a sign change of the summed powers of the first pulse path.
// - enable bit 13 covers a sign change of the summed powers of the second pulse path.
// - enable bit 18 covers a sign change of the summed powers of the third pulse path.
// - enable bit 14 covers each falling edge of the first energy pulse output.
// - enable bit 15 covers each falling edge of the second energy pulse output.
// - enable bit 16 covers each falling edge of the third energy pulse output.
// - pulse events still occur when the matching pin is disabled by pulse mode bits 9 to 11.
// - pulse mode fields 2-0, 5-3 and 8-6 pick the power type of each pulse output.
// - enable bit 17 covers the end of each periodic 8 kHz processing pass.
// - reserved enable bits above 18 have no effect and read as zero.
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mie_params.svh"

module mie_irq_top #(
  parameter int PSRC_W = 8
) (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic                    hready,
  input  wire mie_pkg::mie_word_t      hwdata,
  output var  mie_pkg::mie_word_t      hrdata,
  output var  logic                    hreadyout,
  output var  logic                    hresp,
  input  wire mie_pkg::mie_phase_t     act_tot_neg,
  input  wire mie_pkg::mie_phase_t     act_fund_neg,
  input  wire mie_pkg::mie_phase_t     rea_tot_neg,
  input  wire mie_pkg::mie_phase_t     rea_fund_neg,
  input  wire logic [2:0]              path_sum_neg,
  input  wire logic [PSRC_W-1:0]       pulse_src_n,
  input  wire logic                    dsp_pass_done,
  output var  logic [2:0]              energy_pulse_out_n,
  output var  logic                    irq_n
);

  // ==========================================================
  // elaboration checks
  if (PSRC_W != 8) begin : g_bad_w
    $error("pulse source width must be 8");
  end

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
    hit = (a[7:0] == ofs) && (a[31:8] == 24'h00_0000);
  endfunction

  function automatic logic [2:0] chg3(input logic [2:0] cur, input logic [2:0] old);
    chg3 = cur ^ old;
  endfunction

  // state
  mie_pkg::mie_word_t en_r, en_nxt;
  mie_pkg::mie_word_t sts_r, sts_nxt;
  logic [7:0]         acc_r, acc_nxt;
  logic [15:0]        pm_r, pm_nxt;
  logic               wr_pend_r, wr_pend_nxt;
  logic [7:0]         wr_ofs_r, wr_ofs_nxt;
  mie_pkg::mie_word_t hrdata_nxt;
  logic               armed_r;
  logic [2:0]         act_old_r, rea_old_r, sum_old_r, pls_old_r;
  logic [2:0]         act_sel, rea_sel, pls_cur;
  logic [2:0]         ev_act, ev_rea, ev_sum, ev_pls;
  logic [2:0]         pin_nxt;
  mie_pkg::mie_word_t ev_vec;
  logic               addr_ok, rd_sts, irq_nxt;

  // ==========================================================
  // event detection
  // source select for sign monitors
  always_comb begin
    act_sel = acc_r[`MIE_ACC_ASEL] ? act_fund_neg : act_tot_neg;
    rea_sel = acc_r[`MIE_ACC_RSEL] ? rea_fund_neg : rea_tot_neg;
  end

  // pulse source per output
  always_comb begin
    pls_cur[0] = pulse_src_n[pm_r[`MIE_PM_SEL1_LO +: 3]];
    pls_cur[1] = pulse_src_n[pm_r[`MIE_PM_SEL2_LO +: 3]];
    pls_cur[2] = pulse_src_n[pm_r[`MIE_PM_SEL3_LO +: 3]];
  end

  // edge and change terms, quiet until first sample taken
  always_comb begin
    ev_act = armed_r ? chg3(act_sel, act_old_r) : 3'h0;
    ev_rea = armed_r ? chg3(rea_sel, rea_old_r) : 3'h0;
    ev_sum = armed_r ? chg3(path_sum_neg, sum_old_r) : 3'h0;
    ev_pls = armed_r ? (pls_old_r & ~pls_cur) : 3'h0;
  end

  // event vector in status layout
  always_comb begin
    ev_vec = 32'h0000_0000;
    ev_vec[`MIE_B_ACT_A] = ev_act[0];
    ev_vec[`MIE_B_ACT_B] = ev_act[1];
    ev_vec[`MIE_B_ACT_C] = ev_act[2];
    ev_vec[`MIE_B_SUM1]  = ev_sum[0];
    ev_vec[`MIE_B_REA_A] = ev_rea[0];
    ev_vec[`MIE_B_REA_B] = ev_rea[1];
    ev_vec[`MIE_B_REA_C] = ev_rea[2];
    ev_vec[`MIE_B_SUM2]  = ev_sum[1];
    ev_vec[`MIE_B_PLS1]  = ev_pls[0];
    ev_vec[`MIE_B_PLS2]  = ev_pls[1];
    ev_vec[`MIE_B_PLS3]  = ev_pls[2];
    ev_vec[`MIE_B_DSP]   = dsp_pass_done;
    ev_vec[`MIE_B_SUM3]  = ev_sum[2];
  end

  // history registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_r   <= 1'b0;
      act_old_r <= 3'h0;
      rea_old_r <= 3'h0;
      sum_old_r <= 3'h0;
      pls_old_r <= 3'h7;
    end else begin
      armed_r   <= 1'b1;
      act_old_r <= act_sel;
      rea_old_r <= rea_sel;
      sum_old_r <= path_sum_neg;
      pls_old_r <= pls_cur;
    end
  end

  // ==========================================================
  // bus slave and registers
  // next values of registers and bus answers
  always_comb begin
    addr_ok     = hsel && hready && (htrans == `MIE_HTRANS_NSEQ);
    rd_sts      = addr_ok && !hwrite && hit(haddr, `MIE_OFS_STS);
    wr_pend_nxt = addr_ok && hwrite && (haddr[31:8] == 24'h00_0000); // aliases above the map are ignored
    wr_ofs_nxt  = haddr[7:0];
    en_nxt      = en_r;
    acc_nxt     = acc_r;
    pm_nxt      = pm_r;
    if (wr_pend_r) begin
      if (wr_ofs_r == `MIE_OFS_EN)
        en_nxt = hwdata & `MIE_EN_MASK;
      if (wr_ofs_r == `MIE_OFS_ACC)
        acc_nxt = hwdata[7:0];
      if (wr_ofs_r == `MIE_OFS_PM)
        pm_nxt = hwdata[15:0];
    end
    // read clears, a same-cycle event survives
    sts_nxt = (rd_sts ? 32'h0000_0000 : sts_r) | ev_vec;
    irq_nxt = ~|(sts_nxt & en_nxt);
    hrdata_nxt = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      if (hit(haddr, `MIE_OFS_EN))
        hrdata_nxt = en_nxt;
      else if (hit(haddr, `MIE_OFS_STS))
        hrdata_nxt = sts_r;
      else if (hit(haddr, `MIE_OFS_ACC))
        hrdata_nxt = {24'h00_0000, acc_nxt};
      else if (hit(haddr, `MIE_OFS_PM))
        hrdata_nxt = {16'h0000, pm_nxt};
    end
  end

  // pin drive, disabled pins idle high
  always_comb begin
    pin_nxt[0] = pls_cur[0] | pm_r[`MIE_PM_DIS1];
    pin_nxt[1] = pls_cur[1] | pm_r[`MIE_PM_DIS2];
    pin_nxt[2] = pls_cur[2] | pm_r[`MIE_PM_DIS3];
  end

  // register stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r               <= `MIE_EN_RST;
      sts_r              <= 32'h0000_0000;
      acc_r              <= `MIE_ACC_RST;
      pm_r               <= `MIE_PM_RST;
      wr_pend_r          <= 1'b0;
      wr_ofs_r           <= 8'h00;
      hrdata             <= 32'h0000_0000;
      hreadyout          <= 1'b1;
      hresp              <= 1'b0;
      energy_pulse_out_n <= 3'h7;
      irq_n              <= 1'b1;
    end else begin
      en_r               <= en_nxt;
      sts_r              <= sts_nxt;
      acc_r              <= acc_nxt;
      pm_r               <= pm_nxt;
      wr_pend_r          <= wr_pend_nxt;
      wr_ofs_r           <= wr_ofs_nxt;
      hrdata             <= hrdata_nxt;
      hreadyout          <= 1'b1;
      hresp              <= 1'b0;
      energy_pulse_out_n <= pin_nxt;
      irq_n              <= irq_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_sts_read;
    addr_ok && !hwrite && hit(haddr, `MIE_OFS_STS) && (ev_vec == 32'h0000_0000);
  endsequence

  sequence s_quiet;
    (ev_vec == 32'h0000_0000) [*1];
  endsequence

  a_irq_follows_sts: assert property (
    irq_n == ~|($past(sts_nxt) & $past(en_nxt)))
    else $error("request line does not follow status and enable");

  a_act_a_latch: assert property (
    (armed_r && (act_sel[0] != act_old_r[0])) |=> sts_r[`MIE_B_ACT_A])
    else $error("phase A active sign change not latched");

  a_act_src_sel: assert property (
    (acc_r[`MIE_ACC_ASEL] && armed_r && (act_fund_neg[1] != act_old_r[1]))
      |=> sts_r[`MIE_B_ACT_B])
    else $error("fundamental active source not monitored");

  a_rea_c_latch: assert property (
    (armed_r && !acc_r[`MIE_ACC_RSEL] && (rea_tot_neg[2] != rea_old_r[2]))
      |=> sts_r[`MIE_B_REA_C])
    else $error("phase C reactive sign change not latched");

  a_sum3_latch: assert property (
    (armed_r && $changed(path_sum_neg[2]) && $past(armed_r)) |=> sts_r[`MIE_B_SUM3])
    else $error("third path sum sign change not latched");

  a_pulse_while_off: assert property (
    (pm_r[`MIE_PM_DIS1] && ev_pls[0]) |=> (sts_r[`MIE_B_PLS1] && energy_pulse_out_n[0]))
    else $error("disabled pulse output lost its event or drove low");

  a_dsp_latch: assert property (
    dsp_pass_done |=> sts_r[`MIE_B_DSP])
    else $error("processing pass end not latched");

  a_en_reserved: assert property (
    (en_r & ~`MIE_EN_MASK) == 32'h0000_0000)
    else $error("reserved enable bits set");

  a_sts_rd_clear: assert property (
    s_sts_read ##1 s_quiet |=> (sts_r == 32'h0000_0000))
    else $error("status not cleared by read");

  a_sts_sticky: assert property (
    (sts_r[`MIE_B_PLS2] && !rd_sts) |=> sts_r[`MIE_B_PLS2] [*1])
    else $error("status bit dropped without a read");

  a_pulse3_src: assert property (
    (armed_r && pls_old_r[2] && !pulse_src_n[pm_r[`MIE_PM_SEL3_LO +: 3]])
      |=> sts_r[`MIE_B_PLS3])
    else $error("third pulse falling edge not latched");

  // request line against the latched state it stands for
  a_irq_level: assert property (
    irq_n == !(|(sts_r & en_r)))
    else $error("request line does not match enabled status");

  a_act_b_tot: assert property (
    (armed_r && !acc_r[`MIE_ACC_ASEL] && (act_tot_neg[1] != act_old_r[1])) |=> sts_r[`MIE_B_ACT_B])
    else $error("phase B total active sign change not latched");

  a_act_c_latch: assert property (
    (armed_r && (act_sel[2] != act_old_r[2])) |=> sts_r[`MIE_B_ACT_C])
    else $error("phase C active sign change not latched");

  a_rea_a_latch: assert property (
    (armed_r && (rea_sel[0] != rea_old_r[0])) |=> sts_r[`MIE_B_REA_A])
    else $error("phase A reactive sign change not latched");

  a_sum1_latch: assert property (
    (armed_r && (path_sum_neg[0] != sum_old_r[0])) |=> sts_r[`MIE_B_SUM1])
    else $error("first path sum sign change not latched");

  a_sum2_latch: assert property (
    (armed_r && (path_sum_neg[1] != sum_old_r[1])) |=> sts_r[`MIE_B_SUM2])
    else $error("second path sum sign change not latched");

  a_pulse1_fall: assert property (
    (armed_r && pls_old_r[0] && !pls_cur[0]) |=> sts_r[`MIE_B_PLS1])
    else $error("first pulse falling edge not latched");

  a_pulse2_fall: assert property (
    (armed_r && pls_old_r[1] && !pls_cur[1]) |=> sts_r[`MIE_B_PLS2])
    else $error("second pulse falling edge not latched");

  a_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("slave did not answer ready and okay");

endmodule
`default_nettype wire

// file: verif/mie_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====================================
// host bus master model
module mie_host_model (
  input  wire logic               hclk,
  input  wire logic               hreadyout,
  input  wire mie_pkg::mie_word_t hrdata,
  output var  logic               hsel,
  output var  logic [31:0]        haddr,
  output var  logic [1:0]         htrans,
  output var  logic               hwrite,
  output var  logic [2:0]         hsize,
  output var  mie_pkg::mie_word_t hwdata
);
  mie_pkg::mie_word_t rd_smp;
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // read data as it stood at each edge
  always @(posedge hclk) begin
    rd_smp <= hrdata;
  end
  // one word transfer: address phase, then data phase
  task automatic xfer(input logic [31:0] a, input logic w, input mie_pkg::mie_word_t d,
                      output mie_pkg::mie_word_t q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hwdata <= ~d; // released data no longer holds
    #1;
    q = rd_smp;
  endtask
endmodule
`default_nettype wire

// file: verif/test_metering_irq_enable_upper.sv
`timescale 1ns/100ps
`default_nettype none
`include "mie_params.svh"
// ====================================
// bench top
module test_metering_irq_enable_upper;
  logic                hclk = 1'b0;
  logic                hresetn = 1'b0;
  logic                hsel, hwrite, hreadyout, hresp, irq_n;
  logic                dsp = 1'b0;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic [2:0]          hsize, pins;
  mie_pkg::mie_word_t  hwdata, hrdata, q;
  mie_pkg::mie_phase_t at = '0, af = '0, rt = '0, rf = '0, ps = '0;
  logic [7:0]          src = 8'hFF;
  int                  fails = 0, samples_checked = 0, cycles = 0;

  always #50 hclk = ~hclk;

  mie_irq_top #(.PSRC_W(8)) i_mie_irq_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .act_tot_neg(at), .act_fund_neg(af), .rea_tot_neg(rt),
    .rea_fund_neg(rf), .path_sum_neg(ps), .pulse_src_n(src), .dsp_pass_done(dsp),
    .energy_pulse_out_n(pins), .irq_n(irq_n));
  mie_host_model i_mie_host_model (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // verdict and end of run
  task automatic report_and_stop();
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // compare one value
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input mie_pkg::mie_word_t d);
    i_mie_host_model.xfer({24'h00_0000, a}, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input mie_pkg::mie_word_t e, input string n);
    i_mie_host_model.xfer({24'h00_0000, a}, 1'b0, 32'h0000_0000, q);
    chk(n, e, q);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // one event of a status bit, raised then undone
  task automatic cause(input int b, input logic fund);
    for (int k = 0; k < 2; k++) begin
      @(posedge hclk);
      case (b)
        6, 7, 8: if (fund) af[b-6] <= ~af[b-6]; else at[b-6] <= ~at[b-6];
        10, 11, 12: if (fund) rf[b-10] <= ~rf[b-10]; else rt[b-10] <= ~rt[b-10];
        9: ps[0] <= ~ps[0];
        13: ps[1] <= ~ps[1];
        18: ps[2] <= ~ps[2];
        14, 15, 16: src[b-13] <= ~src[b-13];
        17: dsp <= ~dsp;
        default: src[0] <= ~src[0];
      endcase
    end
    step(2);
  endtask
  // reset values, writable bits, unmapped place
  task automatic t_regs();
    rd(`MIE_OFS_EN, 32'h0000_0000, "en_reset");
    wr(`MIE_OFS_EN, 32'hFFFF_FFFF);
    rd(`MIE_OFS_EN, 32'h0007_FFC0, "en_mask");
    rd(8'h10, 32'h0000_0000, "unmapped");
    chk("hresp", 32'h0000_0000, hresp);
    chk("hreadyout", 32'h0000_0001, hreadyout);
    chk("irq_idle", 32'h0000_0001, irq_n);
    wr(`MIE_OFS_EN, 32'h0000_0000);
    i_mie_host_model.xfer(32'h0000_0100, 1'b1, 32'hFFFF_FFFF, q); // alias above the map
    rd(`MIE_OFS_EN, 32'h0000_0000, "en_alias");
  endtask
  // reset in mid run drops enables, status and request
  task automatic t_reset();
    wr(`MIE_OFS_EN, 32'hFFFF_FFFF);
    cause(17, 1'b0);
    chk("irq_pre", 32'h0000_0000, irq_n);
    @(posedge hclk);
    hresetn <= 1'b0;
    step(2);
    @(posedge hclk);
    hresetn <= 1'b1;
    step(2);
    chk("irq_rst", 32'h0000_0001, irq_n);
    rd(`MIE_OFS_EN, 32'h0000_0000, "en_rst");
    rd(`MIE_OFS_STS, 32'h0000_0000, "sts_rst");
  endtask
  // every event bit, masked then enabled
  task automatic t_bits();
    wr(`MIE_OFS_PM, 32'h0000_0ED1); // pins off, sources 1, 2, 3
    for (int b = 6; b <= 18; b++) begin
      wr(`MIE_OFS_EN, 32'h0000_0000);
      rd(`MIE_OFS_STS, 32'h0000_0000, "sts_idle");
      cause(b, 1'b0);
      chk("irq_masked", 32'h0000_0001, irq_n);
      rd(`MIE_OFS_STS, 32'h0000_0001 << b, "sts_masked");
      wr(`MIE_OFS_EN, 32'h0000_0001 << b);
      cause(b, 1'b0);
      chk("irq_on", 32'h0000_0000, irq_n);
      chk("pins_off", 32'h0000_0007, pins);
      rd(`MIE_OFS_STS, 32'h0000_0001 << b, "sts_on");
      step(2);
      chk("irq_clr", 32'h0000_0001, irq_n);
    end
  endtask
  // power type selects and a live pin
  task automatic t_select();
    wr(`MIE_OFS_ACC, 32'h0000_00C0);
    cause(6, 1'b0);
    cause(10, 1'b0);
    cause(0, 1'b0);
    rd(`MIE_OFS_STS, 32'h0000_0000, "sts_unsel");
    cause(6, 1'b1);
    cause(10, 1'b1);
    rd(`MIE_OFS_STS, 32'h0000_0440, "sts_fund");
    wr(`MIE_OFS_PM, 32'h0000_00D1);
    @(posedge hclk);
    src[2] <= 1'b0;
    step(2);
    chk("pin2_low", 32'h0000_0005, pins);
    @(posedge hclk);
    src[2] <= 1'b1;
    step(2);
    rd(`MIE_OFS_STS, 32'h0000_8000, "sts_pin2");
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    step(2);
    t_regs();
    t_bits();
    t_select();
    t_reset();
    report_and_stop();
  end
  // hang guard
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end
endmodule
`default_nettype wire
